/* File: core/cbp_pkg.sv */
// constants and types for the local bus pin logic
// ==========================================
// Notes on behaviour
// - timer wave outputs stay driven during bus hold, never floated.
// - each timer output gives single pulse or continuous waveform per its mode.
// - dma request pins are active high levels, synchronised inside.
// - nmi rising edge latched, synchronised, type 2 taken at next instruction boundary.
// - nmi has no mask; every rising edge leads to service; here a high sampled on one clock edge only is dropped by the synchroniser.
// - maskable irq pins used as inputs are active high and synchronised.
// - irq pins 2 and 3 may drive active low acknowledge outputs instead.
// - each maskable irq input selects edge or level detection.
// - slave mode reassigns the functions of irq pins 1 to 3; pin 0 stays a request input.
// - address bits 19..16 driven on upper lines in the address state.
// - later states drive cycle origin line low for cpu, high for dma/refresh.
// - later states hold the other three upper status lines low.
// - upper lines and middle address byte float during hold or reset.
// - address bits 15..8 driven and valid from address state to final state.
// - low byte carries address bits 7..0 first, then data in later states.
// - multiplexed low byte floats during hold and reset.
// - all pin timing follows the processor clock, running through reset and hold.
package cbp_pkg;
  // ==========================================
  // widths and positions
  localparam int ADDR_W = 20;
  localparam int HI_W = 4;
  localparam int BYTE_W = 8;
  localparam int HI_LSB = 16;
  localparam int MID_LSB = 8;
  localparam int N_IRQ = 4;
  localparam int N_DMA = 2;
  localparam int N_TMR = 2;
  // synchronised pin vector layout
  localparam int PIN_DMA = 0;
  localparam int PIN_NMI = 2;
  localparam int PIN_IRQ = 3;
  localparam int PIN_W = 7;
  // ==========================================
  // encodings and reset values
  localparam logic TMR_SINGLE = 1'b0;
  localparam logic TMR_CONT = 1'b1;
  localparam logic [N_TMR-1:0] TMR_RST = 2'h3;
  localparam logic [BYTE_W-1:0] NMI_TYPE = 8'h02;
  localparam logic [HI_W-2:0] STATUS_LOW = 3'h0;
  typedef enum logic [2:0] {
    BS_IDLE,
    BS_HOLD,
    BS_ADDR,
    BS_SECOND,
    BS_THIRD,
    BS_WAIT,
    BS_FINAL
  } cbp_bus_e;
endpackage : cbp_pkg

/* File: core/cbp_pin_logic.sv */
// local bus, request input and timer output pin logic
//
`timescale 1ns/1ps
module cbp_pin_logic
  import cbp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  // core side bus cycle request
  input wire logic i_cycle_req,
  input wire logic [ADDR_W-1:0] i_cycle_addr,
  input wire logic i_cycle_write,
  input wire logic [BYTE_W-1:0] i_cycle_wdata,
  input wire logic i_cycle_dma,
  input wire logic i_wait_req,
  input wire logic i_hold,
  output logic o_bus_idle,
  output logic o_hold_ack,
  output logic o_cycle_done,
  output logic [BYTE_W-1:0] o_cycle_rdata,
  // bus pins
  output logic [HI_W-1:0] o_addr_hi,
  output logic o_addr_hi_oe,
  output logic [BYTE_W-1:0] o_addr_mid,
  output logic o_addr_mid_oe,
  input wire logic [BYTE_W-1:0] i_muxed_addr_data,
  output logic [BYTE_W-1:0] o_muxed_addr_data,
  output logic o_muxed_addr_data_oe,
  // timers
  input wire logic [N_TMR-1:0] i_tmr_mode,
  input wire logic [N_TMR-1:0] i_tmr_fire,
  output logic o_timer_wave_out_0,
  output logic o_timer_wave_out_1,
  // dma request pins
  input wire logic i_dma_request_ch0,
  input wire logic i_dma_request_ch1,
  output logic [N_DMA-1:0] o_dma_req,
  // nmi
  input wire logic i_nmi,
  input wire logic i_instr_boundary,
  output logic o_nmi_take,
  output logic [BYTE_W-1:0] o_nmi_type,
  // maskable interrupt pins
  input wire logic i_irq_in_0,
  input wire logic i_irq_in_1_slave_select,
  input wire logic i_irq_in_2_ack_out_0,
  output logic o_irq_in_2_ack_out_0,
  output logic o_irq_in_2_ack_out_0_oe,
  input wire logic i_irq_in_3_ack_out_1,
  output logic o_irq_in_3_ack_out_1,
  output logic o_irq_in_3_ack_out_1_oe,
  input wire logic [N_IRQ-1:0] i_irq_edge_mode,
  input wire logic [N_IRQ-1:0] i_irq_clear,
  input wire logic [1:0] i_ack_out_en,
  input wire logic [1:0] i_int_ack,
  input wire logic i_slave_mode,
  input wire logic i_slave_irq,
  output logic [N_IRQ-1:0] o_irq_req,
  output logic o_slave_select
);

  // ==========================================
  // state
  typedef struct packed {
    cbp_bus_e st;
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic [BYTE_W-1:0] wdata;
    logic dma;
    logic [HI_W-1:0] hi_out;
    logic hi_oe;
    logic [BYTE_W-1:0] mid_out;
    logic mid_oe;
    logic [BYTE_W-1:0] ad_out;
    logic ad_oe;
    logic idle;
    logic hold_ack;
    logic done;
    logic [BYTE_W-1:0] rdata;
    logic [N_TMR-1:0] tmr;
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] flt;
    logic [PIN_W-1:0] flt_prev;
    logic nmi_pend;
    logic nmi_take;
    logic [N_IRQ-1:0] irq_lat;
    logic [N_IRQ-1:0] irq_req;
    logic [1:0] ack_out;
    logic [1:0] ack_oe;
    logic slave_sel;
    logic [BYTE_W-1:0] nmi_type;
  } cbp_state_s;

  cbp_state_s q;
  cbp_state_s d;
  logic [PIN_W-1:0] pins;
  logic [N_IRQ-1:0] irq_lvl;
  logic [N_IRQ-1:0] irq_rise;
  logic nmi_rise;

  assign pins = {i_irq_in_3_ack_out_1, i_irq_in_2_ack_out_0, i_irq_in_1_slave_select, i_irq_in_0, i_nmi,
                 i_dma_request_ch1, i_dma_request_ch0};
  assign irq_lvl = q.flt[PIN_IRQ +: N_IRQ];
  assign irq_rise = irq_lvl & ~q.flt_prev[PIN_IRQ +: N_IRQ];
  assign nmi_rise = q.flt[PIN_NMI] & ~q.flt_prev[PIN_NMI];

  // ==========================================
  // next state
  always_comb begin
    d = q;
    d.done = 1'b0;
    // three stage pin synchroniser, change accepted when stages two and three agree
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.flt_prev = q.flt;
    for (int i = 0; i < PIN_W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.flt[i] = q.s3[i];
      end
    end
    // bus sequencer
    case (q.st)
      BS_IDLE: begin
        if (i_hold) begin
          d.st = BS_HOLD;
        end else if (i_cycle_req) begin
          d.st = BS_ADDR;
          d.addr = i_cycle_addr;
          d.wr = i_cycle_write;
          d.wdata = i_cycle_wdata;
          d.dma = i_cycle_dma;
        end
      end
      BS_HOLD: begin
        if (!i_hold) begin
          d.st = BS_IDLE;
        end
      end
      BS_ADDR: d.st = BS_SECOND;
      BS_SECOND: d.st = BS_THIRD;
      BS_THIRD, BS_WAIT: begin
        d.st = i_wait_req ? BS_WAIT : BS_FINAL;
      end
      BS_FINAL: begin
        d.st = BS_IDLE;
        d.done = 1'b1;
        // bus data is timed by the processor clock, so it is taken directly in the final state
        d.rdata = i_muxed_addr_data;
      end
      default: d.st = BS_IDLE;
    endcase
    // pin drive follows the state being entered
    case (d.st)
      BS_ADDR: begin
        d.hi_out = d.addr[HI_LSB +: HI_W];
        d.hi_oe = 1'b1;
        d.mid_out = d.addr[MID_LSB +: BYTE_W];
        d.mid_oe = 1'b1;
        d.ad_out = d.addr[BYTE_W-1:0];
        d.ad_oe = 1'b1;
      end
      BS_SECOND, BS_THIRD, BS_WAIT, BS_FINAL: begin
        d.hi_out = {d.dma, STATUS_LOW};
        d.hi_oe = 1'b1;
        d.ad_out = d.wdata;
        d.ad_oe = d.wr;
      end
      BS_HOLD: begin
        d.hi_oe = 1'b0;
        d.mid_oe = 1'b0;
        d.ad_oe = 1'b0;
      end
      default: begin
        d.ad_oe = 1'b0;
      end
    endcase
    d.idle = (d.st == BS_IDLE);
    d.hold_ack = (d.st == BS_HOLD);
    // timer waveforms, never floated
    for (int t = 0; t < N_TMR; t++) begin
      if (i_tmr_mode[t] == TMR_CONT) begin
        d.tmr[t] = i_tmr_fire[t] ? ~q.tmr[t] : q.tmr[t];
      end else begin
        d.tmr[t] = ~i_tmr_fire[t];
      end
    end
    // nmi, unmaskable, set wins over the taking
    d.nmi_take = q.nmi_pend & i_instr_boundary;
    d.nmi_pend = nmi_rise | (q.nmi_pend & ~i_instr_boundary);
    // maskable requests, edge latches keep set over clear
    for (int k = 0; k < N_IRQ; k++) begin
      d.irq_lat[k] = irq_rise[k] | (q.irq_lat[k] & ~i_irq_clear[k]);
      d.irq_req[k] = i_irq_edge_mode[k] ? d.irq_lat[k] : irq_lvl[k];
    end
    if (i_slave_mode) begin
      d.irq_req[N_IRQ-1:1] = '0;
      d.slave_sel = irq_lvl[1];
      d.ack_out = {i_slave_irq, ~i_int_ack[0]};
      d.ack_oe = {1'b1, i_ack_out_en[0]};
    end else begin
      d.slave_sel = 1'b0;
      d.ack_out = ~i_int_ack;
      d.ack_oe = i_ack_out_en;
      d.irq_req[3:2] = d.irq_req[3:2] & ~i_ack_out_en;
      d.irq_lat[3:2] = d.irq_lat[3:2] & ~i_ack_out_en;
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.st <= BS_IDLE;
      q.tmr <= TMR_RST;
      q.idle <= 1'b1;
      q.nmi_type <= NMI_TYPE;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // outputs
  assign o_bus_idle = q.idle;
  assign o_hold_ack = q.hold_ack;
  assign o_cycle_done = q.done;
  assign o_cycle_rdata = q.rdata;
  assign o_addr_hi = q.hi_out;
  assign o_addr_hi_oe = q.hi_oe;
  assign o_addr_mid = q.mid_out;
  assign o_addr_mid_oe = q.mid_oe;
  assign o_muxed_addr_data = q.ad_out;
  assign o_muxed_addr_data_oe = q.ad_oe;
  assign o_timer_wave_out_0 = q.tmr[0];
  assign o_timer_wave_out_1 = q.tmr[1];
  assign o_dma_req = q.flt[PIN_DMA +: N_DMA];
  assign o_nmi_take = q.nmi_take;
  assign o_nmi_type = q.nmi_type;
  assign o_irq_req = q.irq_req;
  assign o_slave_select = q.slave_sel;
  assign o_irq_in_2_ack_out_0 = q.ack_out[0];
  assign o_irq_in_2_ack_out_0_oe = q.ack_oe[0];
  assign o_irq_in_3_ack_out_1 = q.ack_out[1];
  assign o_irq_in_3_ack_out_1_oe = q.ack_oe[1];

  // ==========================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_addr_state_hi: assert property ((q.st == BS_ADDR) |-> o_addr_hi == q.addr[HI_LSB +: HI_W] && o_addr_hi_oe)
    else $error("upper lines not carrying address in address state");
  a_status_origin: assert property ((q.st inside {BS_SECOND, BS_THIRD, BS_WAIT, BS_FINAL}) |->
    o_addr_hi[HI_W-1] == q.dma)
    else $error("cycle origin line wrong");
  a_status_low: assert property ((q.st inside {BS_SECOND, BS_THIRD, BS_WAIT, BS_FINAL}) |->
    o_addr_hi[HI_W-2:0] == STATUS_LOW)
    else $error("status lines not low");
  a_hold_float: assert property ((q.st == BS_HOLD) |-> !o_addr_hi_oe && !o_addr_mid_oe)
    else $error("upper or middle lines driven in hold");
  a_mid_stable: assert property ((q.st == BS_ADDR) |=> (o_addr_mid == $past(o_addr_mid) && o_addr_mid_oe) [*3])
    else $error("middle address byte changed inside cycle");
  a_ad_sequence: assert property ((q.st == BS_ADDR && q.wr) |-> o_muxed_addr_data == q.addr[BYTE_W-1:0]
    ##1 o_muxed_addr_data == q.wdata && o_muxed_addr_data_oe)
    else $error("low byte address then data order broken");
  a_ad_hold_float: assert property ((q.st == BS_HOLD) |-> !o_muxed_addr_data_oe)
    else $error("low byte driven in hold");
  a_cycle_order: assert property ((q.st == BS_ADDR) |=> q.st == BS_SECOND ##1 q.st == BS_THIRD)
    else $error("bus state order broken");
  a_final_done: assert property ((q.st == BS_FINAL) |=> o_cycle_done && q.st == BS_IDLE)
    else $error("final state did not end cycle");
  a_nmi_taken: assert property ((nmi_rise && !q.nmi_pend) ##1 i_instr_boundary |=> o_nmi_take)
    else $error("nmi edge not serviced at boundary");
  a_single_pulse: assert property ((i_tmr_mode[0] == TMR_SINGLE && i_tmr_fire[0]) |=> !o_timer_wave_out_0)
    else $error("single pulse missing");
  a_irq_level: assert property ((!i_slave_mode && !i_irq_edge_mode[0]) |=> o_irq_req[0] == $past(irq_lvl[0]))
    else $error("level request not followed");
  a_dma_sync: assert property ((q.s2[PIN_DMA] == q.s3[PIN_DMA]) |=> o_dma_req[0] == $past(q.s3[PIN_DMA]))
    else $error("dma request not synchronised");
  a_dma_sync_ch1: assert property ((q.s2[PIN_DMA+1] == q.s3[PIN_DMA+1]) |=>
    o_dma_req[1] == $past(q.s3[PIN_DMA+1]))
    else $error("second dma request not synchronised");
  a_addr_state_mid: assert property ((q.st == BS_ADDR) |->
    o_addr_mid == q.addr[MID_LSB +: BYTE_W] && o_addr_mid_oe)
    else $error("middle lines not carrying address in address state");
  a_addr_state_low: assert property ((q.st == BS_ADDR) |->
    o_muxed_addr_data == q.addr[BYTE_W-1:0] && o_muxed_addr_data_oe)
    else $error("low byte not carrying address in address state");
  a_read_release: assert property ((q.st inside {BS_SECOND, BS_THIRD, BS_WAIT, BS_FINAL} && !q.wr) |->
    !o_muxed_addr_data_oe)
    else $error("low byte driven during read data states");
  a_read_capture: assert property ((q.st == BS_FINAL) |=>
    o_cycle_rdata == $past(i_muxed_addr_data))
    else $error("read byte not taken in final state");
  a_wait_insert: assert property ((q.st inside {BS_THIRD, BS_WAIT} && i_wait_req) |=>
    q.st == BS_WAIT)
    else $error("wait state not inserted");
  a_wait_leave: assert property ((q.st inside {BS_THIRD, BS_WAIT} && !i_wait_req) |=>
    q.st == BS_FINAL)
    else $error("final state not entered after waits");
  a_done_pulse: assert property (o_cycle_done |=>
    !o_cycle_done)
    else $error("cycle done longer than one cycle");
  a_hold_flags: assert property ((q.st == BS_HOLD) |->
    o_hold_ack && !o_bus_idle)
    else $error("hold state flags wrong");
  a_hold_entry: assert property ((q.st == BS_IDLE && i_hold) |=>
    q.st == BS_HOLD)
    else $error("hold not granted from idle");
  a_nmi_latch: assert property (nmi_rise |=>
    q.nmi_pend)
    else $error("nmi edge not latched");
  a_nmi_serviced: assert property ((q.nmi_pend && i_instr_boundary) |=>
    o_nmi_take && o_nmi_type == NMI_TYPE)
    else $error("pending nmi not taken at boundary");
  a_timer_toggle: assert property ((i_tmr_mode[1] == TMR_CONT && i_tmr_fire[1]) |=>
    o_timer_wave_out_1 != $past(o_timer_wave_out_1))
    else $error("continuous timer output did not toggle");
  a_timer_steady: assert property ((i_tmr_mode[0] == TMR_CONT && !i_tmr_fire[0]) |=>
    $stable(o_timer_wave_out_0))
    else $error("continuous timer output moved without expiry");
  a_irq_filter: assert property ((q.s2[PIN_IRQ] != q.s3[PIN_IRQ]) |=>
    irq_lvl[0] == $past(irq_lvl[0]))
    else $error("request changed before synchroniser stages agreed");
  a_ack_drive: assert property ((!i_slave_mode && i_ack_out_en[0]) |=>
    o_irq_in_2_ack_out_0_oe && o_irq_in_2_ack_out_0 == !$past(i_int_ack[0]))
    else $error("acknowledge output not driven low on acknowledge");
  a_ack_masks_req: assert property ((!i_slave_mode && i_ack_out_en[1]) |=>
    !o_irq_req[N_IRQ-1])
    else $error("pin used as acknowledge output still requests");
  a_slave_pins: assert property (i_slave_mode |=>
    o_irq_req[N_IRQ-1:1] == '0 && o_irq_in_3_ack_out_1_oe && o_slave_select == $past(irq_lvl[1]))
    else $error("slave mode pin roles wrong");
  a_master_pins: assert property (!i_slave_mode |=>
    !o_slave_select)
    else $error("slave select active in master mode");

  c_write_cycle: cover property (q.st == BS_ADDR && q.wr ##4 o_cycle_done);
  c_wait_cycle: cover property (q.st == BS_WAIT ##1 q.st == BS_FINAL);
  c_hold: cover property (q.st == BS_HOLD ##1 q.st == BS_IDLE);
  c_nmi: cover property (o_nmi_take);
  c_read_cycle: cover property (q.st == BS_FINAL && !q.wr ##1 o_cycle_done);

endmodule : cbp_pin_logic

/* File: bench/cbp_bus_mem.sv */
// memory on the local bus: takes the address, stores and returns data bytes
`timescale 1ns/1ps
module cbp_bus_mem
  import cbp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_bus_idle,
  input wire logic i_hold_ack,
  input wire logic [HI_W-1:0] i_addr_hi,
  input wire logic [BYTE_W-1:0] i_addr_mid,
  input wire logic [BYTE_W-1:0] i_ad,
  input wire logic i_ad_oe,
  output logic [BYTE_W-1:0] o_ad
);
  logic [BYTE_W-1:0] mem [int];
  logic [ADDR_W-1:0] adr_q = '0;
  int ph_q = 0;
  // ==========================================
  // address in the first state, data after it
  always @(posedge i_clk) begin
    ph_q <= i_bus_idle ? 0 : ph_q + 1;
    if (!i_bus_idle && ph_q == 0) begin
      adr_q <= {i_addr_hi, i_addr_mid, i_ad};
    end
    if (ph_q == 1 && i_ad_oe) begin
      mem[adr_q] = i_ad;
    end
  end
  // released lines show the inverse, never a stale byte
  always @* begin
    o_ad = mem.exists(adr_q) ? mem[adr_q] : 8'h5A;
    if (i_bus_idle || i_hold_ack || ph_q == 0) begin
      o_ad = ~o_ad;
    end
  end
endmodule : cbp_bus_mem

/* File: bench/cbp_pin_logic_tb_top.sv */
// testbench: bus cycles, hold, timers and request pins against a bench model
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %0h seen %0h", n, e, a); end end
module cbp_pin_logic_tb_top
  import cbp_pkg::*;
;
  logic i_clk = 0, i_rst_n = 0, req = 0, wr = 0, dma = 0, wt = 0, hold = 0;
  logic bnd = 0, slv = 0, sirq = 0, nmi = 0;
  logic [ADDR_W-1:0] adr = '0;
  logic [7:0] wd = '0;
  logic [1:0] tmode = '0, tfire = '0, drq = '0, aen = '0, iack = '0, tv;
  logic [3:0] irq = '0, emode = '0, iclr = '0;
  wire idle, hack, done, hi_oe, mid_oe, ad_oe, t0, t1, ntake, p2o, p2e, p3o, p3e, ssel;
  wire [3:0] hi, ireq;
  wire [7:0] rdata, mid, ad_o, mem_ad, ntype;
  wire [1:0] dreq;
  int miscompares = 0, checks_done = 0, i;
  logic [7:0] ref_mem [int];
  logic [19:0] a;
  always #12.5 i_clk = ~i_clk;
  cbp_pin_logic dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cycle_req(req), .i_cycle_addr(adr),
    .i_cycle_write(wr), .i_cycle_wdata(wd), .i_cycle_dma(dma), .i_wait_req(wt), .i_hold(hold),
    .o_bus_idle(idle), .o_hold_ack(hack), .o_cycle_done(done), .o_cycle_rdata(rdata),
    .o_addr_hi(hi), .o_addr_hi_oe(hi_oe), .o_addr_mid(mid), .o_addr_mid_oe(mid_oe),
    .i_muxed_addr_data(ad_oe ? ad_o : mem_ad), .o_muxed_addr_data(ad_o), .o_muxed_addr_data_oe(ad_oe),
    .i_tmr_mode(tmode), .i_tmr_fire(tfire), .o_timer_wave_out_0(t0), .o_timer_wave_out_1(t1),
    .i_dma_request_ch0(drq[0]), .i_dma_request_ch1(drq[1]), .o_dma_req(dreq), .i_nmi(nmi),
    .i_instr_boundary(bnd), .o_nmi_take(ntake), .o_nmi_type(ntype), .i_irq_in_0(irq[0]),
    .i_irq_in_1_slave_select(irq[1]), .i_irq_in_2_ack_out_0(p2e ? p2o : irq[2]),
    .o_irq_in_2_ack_out_0(p2o), .o_irq_in_2_ack_out_0_oe(p2e), .i_irq_in_3_ack_out_1(p3e ? p3o : irq[3]),
    .o_irq_in_3_ack_out_1(p3o), .o_irq_in_3_ack_out_1_oe(p3e), .i_irq_edge_mode(emode),
    .i_irq_clear(iclr), .i_ack_out_en(aen), .i_int_ack(iack), .i_slave_mode(slv),
    .i_slave_irq(sirq), .o_irq_req(ireq), .o_slave_select(ssel));
  cbp_bus_mem mem (.i_clk(i_clk), .i_bus_idle(idle), .i_hold_ack(hack), .i_addr_hi(hi),
    .i_addr_mid(mid), .i_ad(ad_o), .i_ad_oe(ad_oe), .o_ad(mem_ad));
  // ==========================================
  // helpers
  task tk(int n);
    repeat (n) @(posedge i_clk);
  endtask : tk
  task fin(string s);
    $display("test %0s finished", s);
  endtask : fin
  task results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  task automatic cyc(logic [19:0] ca, logic w, logic [7:0] d, logic dm, int nw);
    int k;
    @(posedge i_clk);
    req <= 1; adr <= ca; wr <= w; wd <= d; dma <= dm;
    @(posedge i_clk);
    req <= 0;
    for (k = 1; k < 20; k++) begin
      #1;
      if (done === 1'b1) break;
      if (k == 1) begin
        `CHK("addr hi", ca[19:16], hi)
        `CHK("ad addr", ca[7:0], ad_o)
        `CHK("oe", 3'h7, {hi_oe, mid_oe, ad_oe})
      end else begin
        `CHK("status", {dm, 3'h0}, hi)
        `CHK("ad dir", w, ad_oe)
        if (w) `CHK("ad data", d, ad_o)
      end
      `CHK("addr mid", ca[15:8], mid)
      @(posedge i_clk);
      wt <= (k >= 2 && k < 2 + nw);
    end
    `CHK("cycle len", 5 + nw, k)
    if (w) ref_mem[ca] = d;
    else `CHK("rdata", ref_mem[ca], rdata)
  endtask : cyc
  // ==========================================
  // tests
  initial begin
    tk(20000);
    miscompares++;
    results;
  end
  initial begin
    void'($urandom(24090));
    tk(4);
    #1;
    `CHK("reset oe", 3'h0, {hi_oe, mid_oe, ad_oe})
    `CHK("reset t", 3'h7, {t1, t0, idle})
    tk(1);
    i_rst_n <= 1;
    fin("reset");
    for (i = 0; i < 6; i++) begin
      a = $urandom;
      cyc(a, 1, $urandom, i[0], i % 3);
      cyc(a, 0, 8'h00, $urandom, 2 - i % 3);
    end
    fin("bus");
    tk(1);
    hold <= 1; req <= 1; tmode <= 2'h3;
    tk(1);
    req <= 0;
    tk(2);
    #1;
    `CHK("hold ack", 1'b1, hack)
    `CHK("float", 3'h0, {hi_oe, mid_oe, ad_oe})
    tv = {t1, t0};
    tk(1);
    tfire <= 2'h3;
    tk(1);
    tfire <= 2'h0;
    #1;
    `CHK("toggle", ~tv, {t1, t0})
    tmode <= 2'h0;
    tfire <= 2'h3;
    tk(1);
    tfire <= 2'h0;
    hold <= 0;
    #1;
    `CHK("pulse", 2'h0, {t1, t0})
    tk(2);
    #1;
    `CHK("release", 2'h2, {idle, hi_oe})
    fin("hold");
    drq <= 2'h1;
    tk(6);
    `CHK("dma", 2'h1, dreq)
    drq <= 2'h2;
    tk(6);
    `CHK("dma", 2'h2, dreq)
    for (i = 0; i < 4; i++) begin
      irq <= 4'h1 << i;
      tk(6);
      `CHK("irq level", 4'h1 << i, ireq)
    end
    irq <= 4'h0;
    emode <= 4'hF;
    iclr <= 4'hF;
    tk(1);
    iclr <= 4'h0;
    tk(5);
    irq <= 4'h2;
    tk(6);
    `CHK("irq edge", 4'h2, ireq)
    iclr <= 4'h2;
    tk(1);
    iclr <= 4'h0;
    tk(2);
    `CHK("irq clear", 4'h0, ireq)
    aen <= 2'h3; iack <= 2'h1;
    tk(2);
    `CHK("ack", 4'hB, {p2e, p2o, p3e, p3o})
    aen <= 2'h0; iack <= 2'h0; slv <= 1; sirq <= 1;
    tk(6);
    `CHK("slave", 3'h7, {ssel, p3e, p3o})
    slv <= 0; irq <= 4'h0;
    fin("pins");
    for (i = 0; i < 2; i++) begin
      nmi <= 1;
      tk(2);
      nmi <= 0;
      tk(6);
      bnd <= 1;
      tk(1);
      bnd <= 0;
      #1;
      `CHK("nmi", 9'h102, {ntake, ntype})
    end
    fin("nmi");
    results;
  end
endmodule : cbp_pin_logic_tb_top
